//--- rtl/acr_pkg.sv
package acr_pkg;
  // Register indices on the plain register port.
  localparam logic [2:0] ACR_ADDR_INPUT_SELECT = 3'h0;
  localparam logic [2:0] ACR_ADDR_CONTROL_STATUS = 3'h1;
  localparam logic [2:0] ACR_ADDR_RESULT_LOW = 3'h2;
  localparam logic [2:0] ACR_ADDR_RESULT_HIGH = 3'h3;
  localparam logic [2:0] ACR_ADDR_SHARED_FUNCTION = 3'h4;

  // Field positions of the input select register.
  localparam int ACR_REF_SELECT_LSB = 6;
  localparam int ACR_LEFT_ADJUST_BIT = 5;
  localparam int ACR_CHANNEL_LSB = 0;

  // Field positions of the control and status register.
  localparam int ACR_ENABLE_BIT = 7;
  localparam int ACR_START_BIT = 6;
  localparam int ACR_AUTO_TRIGGER_BIT = 5;
  localparam int ACR_DONE_FLAG_BIT = 4;
  localparam int ACR_IRQ_ENABLE_BIT = 3;
  localparam int ACR_DIVIDER_LSB = 0;

  // Trigger source field position in the shared function register.
  localparam int ACR_TRIGGER_SOURCE_LSB = 5;

  // Values after reset.
  localparam logic [7:0] ACR_INPUT_SELECT_RESET = 8'h00;
  localparam logic [7:0] ACR_CONTROL_STATUS_RESET = 8'h00;
  localparam logic [2:0] ACR_TRIGGER_SOURCE_RESET = 3'h0;
  localparam logic [9:0] ACR_RESULT_RESET = 10'h000;

  // Reference select encodings.
  localparam logic [1:0] ACR_REF_EXTERNAL = 2'h0;
  localparam logic [1:0] ACR_REF_SUPPLY = 2'h1;
  localparam logic [1:0] ACR_REF_INTERNAL = 2'h3;

  // Gain encodings toward the analog front end.
  localparam logic [1:0] ACR_GAIN_1X = 2'h0;
  localparam logic [1:0] ACR_GAIN_10X = 2'h1;
  localparam logic [1:0] ACR_GAIN_200X = 2'h2;

  // Channel code landmarks and the free running trigger source code.
  localparam logic [4:0] ACR_CH_BANDGAP = 5'h1E;
  localparam logic [4:0] ACR_CH_GROUND = 5'h1F;
  localparam logic [2:0] ACR_TRIGGER_FREE_RUN = 3'h0;

  // Conversion lengths in converter clock cycles.
  localparam logic [4:0] ACR_FIRST_CONV_CYCLES = 5'd25;
  localparam logic [4:0] ACR_NORMAL_CONV_CYCLES = 5'd13;

  // Conversion sequencer states, Gray coded.
  typedef enum logic [0:0] {
    ACR_IDLE = 1'b0,
    ACR_CONVERT = 1'b1
  } acr_state_type;
endpackage

//--- rtl/acr_clk_div.sv
`timescale 1ns/1ps
// Divides the system clock into a one-cycle converter clock enable pulse.
module acr_clk_div #(
  parameter int CNT_WIDTH = 7
) (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Control.
  input wire logic i_run,
  input wire logic [2:0] i_div_select,
  // Converter clock enable.
  output logic o_tick
);
  logic [CNT_WIDTH-1:0] count_reg; // Period counter of system clocks.
  logic [CNT_WIDTH-1:0] terminal; // Last count of one period.

  // Codes 0 and 1 both divide by two; the rest by two to the code.
  always_comb begin
    if (i_div_select < 3'h2) begin
      terminal = CNT_WIDTH'(1);
    end else begin
      terminal = CNT_WIDTH'((1 << i_div_select) - 1);
    end
  end

  // Counter held at zero while disabled so the first period is whole.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !i_run) begin
      count_reg <= '0;
    end else if (count_reg >= terminal) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + CNT_WIDTH'(1);
    end
  end

  // A pulse per period, only while running.
  assign o_tick = i_run && (count_reg >= terminal);
endmodule

//--- rtl/acr_top.sv
`timescale 1ns/1ps
// Control registers and conversion sequencer of a 10-bit converter.
module acr_top (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Register port.
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Interrupt side.
  input wire logic i_global_irq_enable,
  input wire logic i_irq_vector_taken,
  output logic o_irq_request,
  // Auto trigger sources; bit 0 is unused, free running has no signal.
  input wire logic [7:0] i_trigger_sources,
  // Analog core result.
  input wire logic [9:0] i_core_result,
  // Analog core control.
  output logic o_converter_power,
  output logic o_converter_clk_en,
  output logic o_sample_start,
  output logic [1:0] o_reference_select,
  output logic o_internal_reference_on,
  output logic o_single_ended,
  output logic [2:0] o_pos_channel,
  output logic [2:0] o_neg_channel,
  output logic [1:0] o_gain,
  output logic o_select_bandgap,
  output logic o_select_ground
);
  import acr_pkg::*;

  // Software visible state.
  logic [1:0] ref_select_reg; // Written reference code.
  logic left_adjust_reg; // Result presentation.
  logic [4:0] channel_reg; // Written channel and gain code.
  logic enable_reg; // Converter power.
  logic auto_trigger_reg; // Auto trigger enable.
  logic done_flag_reg; // Conversion done flag.
  logic irq_enable_reg; // Done interrupt enable.
  logic [2:0] divider_reg; // Clock divider code.
  logic [2:0] trigger_source_reg; // Auto trigger source.

  // Sequencer state.
  acr_state_type state_reg;
  logic [4:0] cycle_reg; // Converter clocks spent in conversion.
  logic long_conv_reg; // Current conversion is the initialising one.
  logic first_pending_reg; // Next conversion must initialise.
  logic [9:0] result_reg; // Last stored result.
  logic result_lock_reg; // Low byte read, high byte pending.
  logic trigger_prev_reg; // Selected trigger level last cycle.
  logic free_run_next; // Restart request after a free running end.
  logic [7:0] rdata_reg; // Read data register.

  // Working signals.
  logic wr_input; // Write to input select.
  logic wr_control; // Write to control and status.
  logic wr_shared; // Write to shared function.
  logic enable_next; // Enable value after this cycle.
  logic trigger_level; // Selected trigger signal.
  logic trigger_edge; // Rising edge of it.
  logic start_req; // Any reason to begin a conversion.
  logic tick; // Converter clock enable.
  logic conv_end; // Last converter clock of a conversion.
  logic [4:0] conv_len; // Length of the running conversion.
  logic [7:0] result_low_view; // Result low byte as presented.
  logic [7:0] result_high_view; // Result high byte as presented.
  logic flag_set; // Hardware sets the done flag.
  logic flag_clear; // Vector or software clears it.

  // Address decode; unmapped addresses write nothing.
  assign wr_input = i_wr && (i_addr == ACR_ADDR_INPUT_SELECT);
  assign wr_control = i_wr && (i_addr == ACR_ADDR_CONTROL_STATUS);
  assign wr_shared = i_wr && (i_addr == ACR_ADDR_SHARED_FUNCTION);

  // The enable seen by a start written in the same write as the enable.
  assign enable_next = wr_control ? i_wdata[ACR_ENABLE_BIT] : enable_reg;

  // Input select register.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ref_select_reg <= ACR_INPUT_SELECT_RESET[7:6];
      left_adjust_reg <= ACR_INPUT_SELECT_RESET[5];
      channel_reg <= ACR_INPUT_SELECT_RESET[4:0];
    end else if (wr_input) begin
      ref_select_reg <= i_wdata[ACR_REF_SELECT_LSB +: 2];
      left_adjust_reg <= i_wdata[ACR_LEFT_ADJUST_BIT];
      channel_reg <= i_wdata[ACR_CHANNEL_LSB +: 5];
    end
  end

  // Control bits other than start and the flag.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      enable_reg <= ACR_CONTROL_STATUS_RESET[7];
      auto_trigger_reg <= ACR_CONTROL_STATUS_RESET[5];
      irq_enable_reg <= ACR_CONTROL_STATUS_RESET[3];
      divider_reg <= ACR_CONTROL_STATUS_RESET[2:0];
    end else if (wr_control) begin
      enable_reg <= i_wdata[ACR_ENABLE_BIT];
      auto_trigger_reg <= i_wdata[ACR_AUTO_TRIGGER_BIT];
      irq_enable_reg <= i_wdata[ACR_IRQ_ENABLE_BIT];
      divider_reg <= i_wdata[ACR_DIVIDER_LSB +: 3];
    end
  end

  // Trigger source in the shared function register.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      trigger_source_reg <= ACR_TRIGGER_SOURCE_RESET;
    end else if (wr_shared) begin
      trigger_source_reg <= i_wdata[ACR_TRIGGER_SOURCE_LSB +: 3];
    end
  end

  // Free running selects no signal, so switching to it makes no edge.
  // Switching between two other sources can make one; that is intended.
  assign trigger_level = (trigger_source_reg == ACR_TRIGGER_FREE_RUN) ? 1'b0
                         : i_trigger_sources[trigger_source_reg];
  assign trigger_edge = trigger_level && !trigger_prev_reg;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      trigger_prev_reg <= 1'b0;
    end else begin
      trigger_prev_reg <= trigger_level;
    end
  end

  // Converter clock from the divider; it only runs while enabled.
  acr_clk_div #(
    .CNT_WIDTH(7)
  ) u_clk_div (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_run(enable_reg),
    .i_div_select(divider_reg),
    .o_tick(tick)
  );

  // A conversion may start only from idle with the converter powered.
  // Requests that land while busy are dropped, as in the real core.
  always_comb begin
    start_req = 1'b0;
    if (state_reg == ACR_IDLE && enable_next) begin
      if (wr_control && i_wdata[ACR_START_BIT]) begin
        start_req = 1'b1;
      end else if (auto_trigger_reg && trigger_edge) begin
        start_req = 1'b1;
      end else if (free_run_next) begin
        start_req = 1'b1;
      end
    end
  end

  assign conv_len = long_conv_reg ? ACR_FIRST_CONV_CYCLES : ACR_NORMAL_CONV_CYCLES;
  assign conv_end = (state_reg == ACR_CONVERT) && tick && (cycle_reg == conv_len - 5'd1);

  // Remember that the next conversion initialises the converter.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      first_pending_reg <= 1'b0;
    end else if (start_req) begin
      // A start taken with the enable write already runs long, so nothing is left pending.
      first_pending_reg <= 1'b0;
    end else if (!enable_reg && enable_next) begin
      first_pending_reg <= 1'b1;
    end
  end

  // Conversion sequencer.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_reg <= ACR_IDLE;
      cycle_reg <= 5'h00;
      long_conv_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ACR_IDLE: begin
          if (start_req) begin
            state_reg <= ACR_CONVERT;
            cycle_reg <= 5'h00;
            // A start written together with enable also initialises.
            long_conv_reg <= first_pending_reg || !enable_reg;
          end
        end
        ACR_CONVERT: begin
          if (!enable_next) begin
            state_reg <= ACR_IDLE;
          end else if (conv_end) begin
            state_reg <= ACR_IDLE;
          end else if (tick) begin
            cycle_reg <= cycle_reg + 5'd1;
          end
        end
      endcase
    end
  end

  // Free running restarts the sequencer one cycle after each end.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      free_run_next <= 1'b0;
    end else begin
      free_run_next <= conv_end && auto_trigger_reg
                       && (trigger_source_reg == ACR_TRIGGER_FREE_RUN);
    end
  end

  // Selections follow the registers only between conversions, so a
  // write during a conversion lands when it completes.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_reference_select <= ACR_INPUT_SELECT_RESET[7:6];
      o_internal_reference_on <= 1'b0;
    end else if (state_reg == ACR_IDLE) begin
      o_reference_select <= ref_select_reg;
      o_internal_reference_on <= (ref_select_reg == ACR_REF_INTERNAL);
    end
  end

  // Channel decode into the analog multiplexer controls.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_single_ended <= 1'b1;
      o_pos_channel <= 3'h0;
      o_neg_channel <= 3'h0;
      o_gain <= ACR_GAIN_1X;
      o_select_bandgap <= 1'b0;
      o_select_ground <= 1'b0;
    end else if (state_reg == ACR_IDLE) begin
      o_select_bandgap <= (channel_reg == ACR_CH_BANDGAP);
      o_select_ground <= (channel_reg == ACR_CH_GROUND);
      o_gain <= ACR_GAIN_1X;
      o_neg_channel <= 3'h0;
      if (channel_reg[4:3] == 2'b00) begin
        o_single_ended <= 1'b1;
        o_pos_channel <= channel_reg[2:0];
      end else if (channel_reg[4:3] == 2'b01) begin
        o_single_ended <= 1'b0;
        o_pos_channel <= {1'b0, channel_reg[2], channel_reg[0]};
        o_neg_channel <= {1'b0, channel_reg[2], 1'b0};
        o_gain <= channel_reg[1] ? ACR_GAIN_200X : ACR_GAIN_10X;
      end else if (channel_reg[4:3] == 2'b10) begin
        o_single_ended <= 1'b0;
        o_pos_channel <= channel_reg[2:0];
        o_neg_channel <= 3'h1;
      end else if (channel_reg[2:1] != 2'b11) begin
        o_single_ended <= 1'b0;
        o_pos_channel <= channel_reg[2:0];
        o_neg_channel <= 3'h2;
      end else begin
        // Bandgap and ground are single ended with no pin selected.
        o_single_ended <= 1'b1;
        o_pos_channel <= 3'h0;
      end
    end
  end

  // Core strobes: power, converter clock and a sample pulse at start.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_sample_start <= 1'b0;
    end else begin
      o_sample_start <= start_req;
    end
  end
  assign o_converter_power = enable_reg;
  assign o_converter_clk_en = tick;

  // The result is held while a low byte read waits for its high byte;
  // a conversion ending then is lost, but still raises the flag.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      result_reg <= ACR_RESULT_RESET;
    end else if (conv_end && !result_lock_reg) begin
      result_reg <= i_core_result;
    end
  end

  // Lock set by a low byte read and released by a high byte read.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      result_lock_reg <= 1'b0;
    end else if (i_rd && i_addr == ACR_ADDR_RESULT_LOW) begin
      result_lock_reg <= 1'b1;
    end else if (i_rd && i_addr == ACR_ADDR_RESULT_HIGH) begin
      result_lock_reg <= 1'b0;
    end
  end

  // Done flag; a set in the same cycle as a clear wins.
  assign flag_set = conv_end;
  assign flag_clear = i_irq_vector_taken
                      || (wr_control && i_wdata[ACR_DONE_FLAG_BIT]);

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      done_flag_reg <= ACR_CONTROL_STATUS_RESET[4];
    end else if (flag_set) begin
      done_flag_reg <= 1'b1;
    end else if (flag_clear) begin
      done_flag_reg <= 1'b0;
    end
  end

  // Software must not write a set flag back by read-modify-write.
  assign o_irq_request = done_flag_reg && irq_enable_reg && i_global_irq_enable;

  // Result views follow the adjust bit with no wait for a conversion.
  always_comb begin
    if (left_adjust_reg) begin
      result_high_view = result_reg[9:2];
      result_low_view = {result_reg[1:0], 6'h00};
    end else begin
      result_high_view = {6'h00, result_reg[9:8]};
      result_low_view = result_reg[7:0];
    end
  end

  // Read data register; unmapped addresses and idle cycles read zero.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !i_rd) begin
      rdata_reg <= 8'h00;
    end else begin
      unique case (i_addr)
        ACR_ADDR_INPUT_SELECT: begin
          rdata_reg <= {ref_select_reg, left_adjust_reg, channel_reg};
        end
        ACR_ADDR_CONTROL_STATUS: begin
          rdata_reg <= {enable_reg, (state_reg == ACR_CONVERT),
                        auto_trigger_reg, done_flag_reg, irq_enable_reg, divider_reg};
        end
        ACR_ADDR_RESULT_LOW: begin
          rdata_reg <= result_low_view;
        end
        ACR_ADDR_RESULT_HIGH: begin
          rdata_reg <= result_high_view;
        end
        ACR_ADDR_SHARED_FUNCTION: begin
          rdata_reg <= {trigger_source_reg, 5'h00};
        end
        default: begin
          rdata_reg <= 8'h00;
        end
      endcase
    end
  end
  assign o_rdata = rdata_reg;
endmodule

//--- testbench/acr_monitor.sv
`timescale 1ns/1ps
// Port-side checker for the converter control block.
module acr_monitor (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Register port.
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // Interrupt and core side.
  input wire logic i_global_irq_enable,
  input wire logic o_irq_request,
  input wire logic o_converter_power,
  input wire logic o_converter_clk_en,
  input wire logic o_sample_start,
  input wire logic [1:0] o_reference_select,
  input wire logic o_internal_reference_on,
  input wire logic o_select_bandgap,
  input wire logic o_select_ground
);
  import acr_pkg::*;
  // All checks live in the one system clock domain.
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Write to the control register, shared by several checks.
  logic ctl_wr;
  assign ctl_wr = i_wr && (i_addr == ACR_ADDR_CONTROL_STATUS);

  a_clk_en_gated: assert property (o_converter_clk_en |-> o_converter_power)
    else $error("converter clock pulse while powered down");
  a_clk_en_spacing: assert property (o_converter_clk_en |=> !o_converter_clk_en)
    else $error("converter clock pulses closer than two cycles");
  a_irq_global: assert property (o_irq_request |-> i_global_irq_enable)
    else $error("interrupt requested with global enable low");
  a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside the read answer cycle");
  a_unmapped_zero: assert property ($past(i_rd) && $past(i_addr) > 3'h4 |-> o_rdata == 8'h00)
    else $error("unmapped register read not zero");
  a_ref_internal: assert property (o_internal_reference_on == (o_reference_select == 2'h3))
    else $error("internal reference state disagrees with reference code");
  a_bg_gnd_excl: assert property (!(o_select_bandgap && o_select_ground))
    else $error("bandgap and ground routed together");
  a_power_write: assert property (ctl_wr |=> o_converter_power == $past(i_wdata[7]))
    else $error("converter power does not follow the enable bit");
  a_first_start: assert property (ctl_wr && i_wdata[7:6] == 2'b11 && !o_converter_power
    |=> o_sample_start)
    else $error("start written with enable did not start");
  a_start_refused: assert property (ctl_wr && i_wdata[7:6] == 2'b01 && !o_converter_power
    |=> !o_sample_start)
    else $error("start accepted while disabled");
  a_start_single: assert property (o_sample_start |=> !o_sample_start)
    else $error("sample start longer than one cycle");

  c_start: cover property (o_sample_start);
  c_irq: cover property (o_irq_request);
  c_unmapped: cover property ($past(i_rd) && $past(i_addr) == 3'h5);
endmodule

bind acr_top acr_monitor i_acr_monitor (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_global_irq_enable(i_global_irq_enable),
  .o_irq_request(o_irq_request), .o_converter_power(o_converter_power),
  .o_converter_clk_en(o_converter_clk_en), .o_sample_start(o_sample_start),
  .o_reference_select(o_reference_select), .o_internal_reference_on(o_internal_reference_on),
  .o_select_bandgap(o_select_bandgap), .o_select_ground(o_select_ground)
);

//--- testbench/acr_top_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the converter control registers.
module acr_top_tb;
  import acr_pkg::*;
  // Design inputs and outputs.
  logic i_sys_clk, i_rst, i_wr, i_rd, i_global_irq_enable, i_irq_vector_taken;
  logic [2:0] i_addr;
  logic [7:0] i_wdata, o_rdata, i_trigger_sources;
  logic [9:0] i_core_result;
  logic o_irq_request, o_converter_power, o_converter_clk_en, o_sample_start;
  logic o_internal_reference_on, o_single_ended, o_select_bandgap, o_select_ground;
  logic [1:0] o_reference_select, o_gain;
  logic [2:0] o_pos_channel, o_neg_channel;
  // Bench state.
  int n_fail, checked, pulses, k, t, t2, p;
  logic [9:0] res;
  logic [8:0] e, m;
  logic [7:0] d;

  acr_top i_acr_top (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_global_irq_enable(i_global_irq_enable), .i_irq_vector_taken(i_irq_vector_taken),
    .o_irq_request(o_irq_request), .i_trigger_sources(i_trigger_sources),
    .i_core_result(i_core_result), .o_converter_power(o_converter_power),
    .o_converter_clk_en(o_converter_clk_en), .o_sample_start(o_sample_start),
    .o_reference_select(o_reference_select), .o_internal_reference_on(o_internal_reference_on),
    .o_single_ended(o_single_ended), .o_pos_channel(o_pos_channel),
    .o_neg_channel(o_neg_channel), .o_gain(o_gain), .o_select_bandgap(o_select_bandgap),
    .o_select_ground(o_select_ground));

  // 10 MHz system clock.
  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end

  // Counts converter clock pulses of the running conversion; restarts at each sample start.
  always @(negedge i_sys_clk) begin
    if (o_sample_start === 1'b1) begin
      pulses = (o_converter_clk_en === 1'b1) ? 1 : 0;
    end else if (o_converter_clk_en === 1'b1) begin
      pulses++;
    end
  end

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle register write.
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask

  // One-cycle register read; the answer stands in the following cycle only.
  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    chk(16'(o_rdata), 16'(exp));
  endtask

  // Waits for the done interrupt, bounded, and checks the conversion length.
  task automatic run_conv(input int exp_pulses);
    // Let a flag clear written at the last edge settle before looking.
    @(negedge i_sys_clk);
    for (t = 0; t < 4000 && o_irq_request !== 1'b1; t++) begin
      @(negedge i_sys_clk);
    end
    chk(16'(pulses), 16'(exp_pulses));
  endtask

  // Expected routing {single ended, positive, negative, gain} of a channel code.
  function automatic logic [8:0] exp_route(input logic [4:0] c);
    if (c < 5'h08) return {1'b1, c[2:0], 3'h0, ACR_GAIN_1X};
    if (c < 5'h10) return {2'b00, c[2], c[0], 1'b0, c[2], 1'b0,
      (c[1] ? ACR_GAIN_200X : ACR_GAIN_10X)};
    if (c < 5'h18) return {1'b0, c[2:0], 3'h1, ACR_GAIN_1X};
    if (c < 5'h1E) return {1'b0, c[2:0], 3'h2, ACR_GAIN_1X};
    return 9'h100;
  endfunction

  // Ends the run with the verdict.
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog: the tests need well under 20000 cycles.
  initial begin
    #2000000;
    n_fail++;
    end_of_test();
  end

  // Main sequence.
  initial begin
    n_fail = 0;
    checked = 0;
    {i_rst, i_wr, i_rd, i_addr, i_wdata} = {1'b1, 13'h0000};
    {i_global_irq_enable, i_irq_vector_taken, i_trigger_sources} = 10'h000;
    i_core_result = 10'h000;
    d = 8'($urandom(32'h4E8E));
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    // Reset values, unused shared bits and the unmapped places read zero.
    for (k = 0; k < 8; k++) rchk(3'(k), 8'h00);
    wr(ACR_ADDR_SHARED_FUNCTION, 8'hFF);
    rchk(ACR_ADDR_SHARED_FUNCTION, 8'hE0);
    $display("test reset and access done");
    // Every channel code with a random reference code.
    for (k = 0; k < 32; k++) begin
      d = {2'($urandom), 1'b0, 5'(k)};
      wr(ACR_ADDR_INPUT_SELECT, d);
      repeat (2) @(posedge i_sys_clk);
      chk(16'({o_reference_select, o_internal_reference_on}), 16'({d[7:6], d[7:6] == 2'h3}));
      chk(16'({o_select_bandgap, o_select_ground}), 16'({k == 30, k == 31}));
      m = (k < 8) ? 9'h1F0 : ((k >= 30) ? 9'h100 : 9'h1FF);
      e = exp_route(5'(k));
      chk(16'({o_single_ended, o_pos_channel, o_neg_channel, o_gain} & m), 16'(e & m));
    end
    $display("test channel decode done");
    // Divider period for every code, then silence while disabled.
    for (k = 0; k < 8; k++) begin
      wr(ACR_ADDR_CONTROL_STATUS, 8'h80 | 8'(k));
      p = 0;
      for (t = 0; p < 3 && t < 1000; t++) begin
        @(negedge i_sys_clk);
        if (o_converter_clk_en === 1'b1) p++;
        if (p == 2 && o_converter_clk_en === 1'b1) t2 = t;
      end
      chk(16'(t - 1 - t2), (k < 2) ? 16'h0002 : 16'(1 << k));
    end
    wr(ACR_ADDR_CONTROL_STATUS, 8'h00);
    pulses = 0;
    repeat (300) @(posedge i_sys_clk);
    chk(16'(pulses), 16'h0000);
    $display("test divider done");
    // First conversion: 25 pulses, selection change held back, result views.
    res = 10'($urandom);
    i_core_result <= res;
    i_global_irq_enable <= 1'b1;
    wr(ACR_ADDR_INPUT_SELECT, 8'h43);
    wr(ACR_ADDR_CONTROL_STATUS, 8'hC8);
    rchk(ACR_ADDR_CONTROL_STATUS, 8'hC8);
    wr(ACR_ADDR_INPUT_SELECT, 8'hDE);
    @(negedge i_sys_clk);
    chk(16'({o_reference_select, o_select_bandgap}), 16'h0002);
    run_conv(25);
    repeat (2) @(posedge i_sys_clk);
    chk(16'({o_reference_select, o_select_bandgap}), 16'h0007);
    chk(16'(o_irq_request), 16'h0001);
    rchk(ACR_ADDR_CONTROL_STATUS, 8'h98);
    i_global_irq_enable <= 1'b0;
    @(negedge i_sys_clk);
    chk(16'(o_irq_request), 16'h0000);
    i_global_irq_enable <= 1'b1;
    rchk(ACR_ADDR_RESULT_LOW, res[7:0]);
    rchk(ACR_ADDR_RESULT_HIGH, {6'h00, res[9:8]});
    wr(ACR_ADDR_INPUT_SELECT, 8'hFE);
    rchk(ACR_ADDR_RESULT_LOW, {res[1:0], 6'h00});
    rchk(ACR_ADDR_RESULT_HIGH, res[9:2]);
    // Whole values are written, never read back and modified.
    wr(ACR_ADDR_CONTROL_STATUS, 8'h98);
    rchk(ACR_ADDR_CONTROL_STATUS, 8'h88);
    $display("test first conversion done");
    // Low byte read locks the result across a second 13-pulse conversion.
    rchk(ACR_ADDR_RESULT_LOW, {res[1:0], 6'h00});
    i_core_result <= ~res;
    wr(ACR_ADDR_CONTROL_STATUS, 8'hC8);
    wr(ACR_ADDR_CONTROL_STATUS, 8'h88);
    run_conv(13);
    rchk(ACR_ADDR_RESULT_HIGH, res[9:2]);
    wr(ACR_ADDR_CONTROL_STATUS, 8'h88);
    rchk(ACR_ADDR_CONTROL_STATUS, 8'h98);
    i_irq_vector_taken <= 1'b1;
    @(posedge i_sys_clk);
    i_irq_vector_taken <= 1'b0;
    @(negedge i_sys_clk);
    chk(16'(o_irq_request), 16'h0000);
    $display("test lock and clear done");
    // Clearing enable mid-conversion aborts it without a flag.
    wr(ACR_ADDR_CONTROL_STATUS, 8'hC8);
    repeat (8) @(posedge i_sys_clk);
    wr(ACR_ADDR_CONTROL_STATUS, 8'h08);
    repeat (80) @(posedge i_sys_clk);
    chk(16'({o_irq_request, o_converter_power}), 16'h0000);
    rchk(ACR_ADDR_CONTROL_STATUS, 8'h08);
    $display("test abort done");
    // Auto trigger on source 2; source 3 is ignored.
    wr(ACR_ADDR_SHARED_FUNCTION, 8'h40);
    wr(ACR_ADDR_CONTROL_STATUS, 8'hA8);
    i_trigger_sources <= 8'h08;
    repeat (80) @(posedge i_sys_clk);
    chk(16'(o_irq_request), 16'h0000);
    i_trigger_sources <= 8'h04;
    run_conv(25);
    wr(ACR_ADDR_CONTROL_STATUS, 8'hB8);
    i_trigger_sources <= 8'h00;
    @(posedge i_sys_clk);
    i_trigger_sources <= 8'h04;
    run_conv(13);
    chk(16'(o_irq_request), 16'h0001);
    $display("test auto trigger done");
    // Switching to free running starts nothing; after one start it restarts itself.
    wr(ACR_ADDR_SHARED_FUNCTION, 8'h00);
    repeat (40) @(posedge i_sys_clk);
    rchk(ACR_ADDR_CONTROL_STATUS, 8'hB8);
    wr(ACR_ADDR_CONTROL_STATUS, 8'hF8);
    run_conv(13);
    wr(ACR_ADDR_CONTROL_STATUS, 8'hB8);
    run_conv(13);
    chk(16'(o_irq_request), 16'h0001);
    $display("test free running done");
    end_of_test();
  end
endmodule
